// [design/nvc_ctrl.sv]
// Nonvolatile memory controller: flash array, write latches, EEPROM, AXI4-Lite regs.
// Assumes one clock, sync active-low reset, and a well-behaved AXI4-Lite master.
`timescale 1ns/1ps
`include "nvc_params.svh"

module nvc_ctrl #(
    parameter int WRITE_CYC = `NVC_WRITE_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    input wire nvc_pkg::nvc_cfg_s cfg,
    input wire logic ptr_rd,
    input wire logic [15:0] ptr_addr,
    output logic [13:0] ptr_data_q,
    output logic cpu_stall_q,
    output logic done_irq_q
);
    // Storage arrays: flash, latches, user IDs, EEPROM
    logic [13:0] flash_mem [0:`NVC_FLASH_WORDS-1];
    logic [13:0] latch_mem [0:`NVC_ROW_WORDS-1];
    logic [13:0] uid_mem [0:3];
    logic [7:0] ee_mem [0:255];

    // Erased contents at power-up: every cell reads all ones
    initial begin
        for (int i = 0; i < `NVC_FLASH_WORDS; i++)
            flash_mem[i] = 14'h3fff;
        for (int i = 0; i < `NVC_ROW_WORDS; i++)
            latch_mem[i] = 14'h3fff;
        for (int i = 0; i < 4; i++)
            uid_mem[i] = 14'h3fff;
        for (int i = 0; i < 256; i++)
            ee_mem[i] = 8'hff;
    end

    // Control and data registers
    logic rd_q, wr_q, write_enable_gate_q, free_q, lwlo_q, regs_q, ie_q, done_q;
    logic [15:0] addr_q;
    logic [13:0] data_q;
    logic [1:0] key_q;
    nvc_pkg::nvc_state_e state_q;
    nvc_pkg::nvc_op_e op_q;
    logic [15:0] tmr_q;
    nvc_pkg::nvc_cfg_s cfg_q;
    logic cfg_take_q;

    // Bus handshake registers
    logic aw_hold_q, w_hold_q;
    logic [7:0] aw_q;
    logic [31:0] wd_q;
    logic [3:0] ws_q;

    // Flash address decode, shared by register and pointer paths
    function automatic logic in_flash(input logic [15:0] a);
        return a[15] && (a[14:0] < 15'(`NVC_FLASH_WORDS));
    endfunction

    // Write-protect region: 00 all, 01 upper half, 10 first quarter, 11 none
    function automatic logic wp_hit(input logic [1:0] f, input logic [12:0] w);
        case (f)
            2'b00: return 1'b1;
            2'b01: return w[12];
            2'b10: return w[12:11] == 2'b00;
            default: return 1'b0;
        endcase
    endfunction

    wire logic protected_w = !cfg_q.cp_flash_n || !cfg_q.cp_ee_n;
    wire logic [12:0] fa_w = addr_q[12:0];

    // Bus write decode
    wire logic wr_go = aw_hold_q && w_hold_q && !s_bvalid;
    wire logic wr_ctrl = wr_go && aw_q == `NVC_OFF_CTRL;
    // Control bits as they stand after this cycle's control write
    wire logic ctl_w = wr_ctrl && ws_q[0];
    wire logic regs_n = ctl_w ? wd_q[`NVC_BIT_REGS] : regs_q;
    wire logic free_n = ctl_w ? wd_q[`NVC_BIT_FREE] : free_q;
    wire logic lwlo_n = ctl_w ? wd_q[`NVC_BIT_LWLO] : lwlo_q;
    wire logic write_enable_gate_n = ctl_w ? wd_q[`NVC_BIT_WRITE_ENABLE_GATE] : write_enable_gate_q;
    wire logic ee_sel_w = regs_n && addr_q[15:8] == 8'(`NVC_EE_BASE >> 8);
    wire logic uid_sel_w = regs_n && addr_q[15:2] == 14'h0000;
    wire logic fl_sel_w = !regs_n && in_flash(addr_q);
    wire logic wr_key = wr_go && aw_q == `NVC_OFF_KEY && ws_q[0];
    wire logic wr_addr = wr_go && aw_q == `NVC_OFF_ADDR;
    wire logic wr_data = wr_go && aw_q == `NVC_OFF_DATA;
    wire logic wr_stat = wr_go && aw_q == `NVC_OFF_STAT;
    wire logic wr_ok = wr_ctrl || wr_key || wr_addr || wr_data || wr_stat
        || (wr_go && aw_q == `NVC_OFF_PTR);

    // Unlock: third step is a WR set right after both keys
    wire logic set_wr = wr_ctrl && ws_q[0] && wd_q[`NVC_BIT_WR] && !wr_q;
    wire logic unlocked = key_q == 2'd2 && write_enable_gate_n;
    wire logic idle_w = state_q == nvc_pkg::NVC_IDLE;
    wire logic start_wr = set_wr && unlocked && idle_w && !protected_w;
    wire logic set_rd = wr_ctrl && ws_q[0] && wd_q[`NVC_BIT_RD];
    // Read ignored while busy or protected
    wire logic do_rd = set_rd && idle_w && !protected_w;

    // Operation chosen at launch
    wire nvc_pkg::nvc_op_e op_w = ee_sel_w ? nvc_pkg::NVC_OP_EE :
        free_n ? nvc_pkg::NVC_OP_ERASE :
        lwlo_n ? nvc_pkg::NVC_OP_LATCH : nvc_pkg::NVC_OP_ROW;
    // Refuse self-write into protected region or invalid space
    wire logic target_ok = ee_sel_w ? 1'b1 : uid_sel_w ? 1'b1 :
        fl_sel_w ? !wp_hit(cfg_q.wrt_field, fa_w) : 1'b0;
    wire logic latch_only = op_w == nvc_pkg::NVC_OP_LATCH;

    // Register read value for the selected space
    wire logic [13:0] cfg_word = {10'h000, cfg_q.cp_flash_n, cfg_q.cp_ee_n, cfg_q.wrt_field};
    wire logic [13:0] rd_word = ee_sel_w ? {6'h00, ee_mem[addr_q[7:0]]} :
        uid_sel_w ? uid_mem[addr_q[1:0]] :
        fl_sel_w ? flash_mem[fa_w] :
        regs_q ? cfg_word : 14'h3fff;

    // Pointer path: flash or EEPROM, read-only
    wire logic [13:0] ptr_word = in_flash(ptr_addr) ? flash_mem[ptr_addr[12:0]] :
        ptr_addr[15:8] == 8'(`NVC_EE_BASE >> 8) ? {6'h00, ee_mem[ptr_addr[7:0]]} : 14'h3fff;

    // Status read mux
    wire logic [31:0] rmux = s_araddr == `NVC_OFF_CTRL ?
        {23'h0, done_q, ie_q, regs_q, lwlo_q, 1'b0, free_q, write_enable_gate_q, wr_q, rd_q} :
        s_araddr == `NVC_OFF_ADDR ? {16'h0, addr_q} :
        s_araddr == `NVC_OFF_DATA ? {18'h0, data_q} :
        s_araddr == `NVC_OFF_STAT ? {27'h0, protected_w, cfg_q.wrt_field,
            state_q != nvc_pkg::NVC_IDLE, done_q} : 32'h0;
    wire logic rd_ok = s_araddr == `NVC_OFF_CTRL || s_araddr == `NVC_OFF_KEY ||
        s_araddr == `NVC_OFF_ADDR || s_araddr == `NVC_OFF_DATA ||
        s_araddr == `NVC_OFF_PTR || s_araddr == `NVC_OFF_STAT;

    // Configuration capture one edge after reset release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_take_q <= 1'b1;
            cfg_q <= '0;
        end else if (cfg_take_q) begin
            cfg_take_q <= 1'b0;
            cfg_q <= cfg;
        end
    end

    // AXI write address and data capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            aw_q <= 8'h00;
            wd_q <= 32'h0;
            ws_q <= 4'h0;
            s_bvalid <= 1'b0;
            s_bresp <= 2'b00;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_hold_q <= 1'b1;
                aw_q <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_hold_q <= 1'b1;
                wd_q <= s_wdata;
                ws_q <= s_wstrb;
            end
            if (wr_go) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp <= wr_ok ? 2'b00 : 2'b10;
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end
    assign s_awready = !aw_hold_q && !s_bvalid;
    assign s_wready = !w_hold_q && !s_bvalid;

    // AXI read channel, one cycle answer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_rvalid <= 1'b0;
            s_rdata <= 32'h0;
            s_rresp <= 2'b00;
        end else if (s_arvalid && s_arready) begin
            s_rvalid <= 1'b1;
            s_rdata <= rmux;
            s_rresp <= rd_ok ? 2'b00 : 2'b10;
        end else if (s_rvalid && s_rready) begin
            s_rvalid <= 1'b0;
        end
    end
    assign s_arready = !s_rvalid;

    // Control bits, unlock tracker and timed operation
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {rd_q, wr_q, write_enable_gate_q, free_q, lwlo_q, regs_q, ie_q, done_q} <= 8'h00;
            key_q <= 2'd0;
            state_q <= nvc_pkg::NVC_IDLE;
            op_q <= nvc_pkg::NVC_OP_ROW;
            tmr_q <= 16'h0000;
            done_irq_q <= 1'b0;
        end else begin
            rd_q <= do_rd;
            if (wr_ctrl && ws_q[0]) begin
                write_enable_gate_q <= wd_q[`NVC_BIT_WRITE_ENABLE_GATE];
                free_q <= wd_q[`NVC_BIT_FREE];
                lwlo_q <= wd_q[`NVC_BIT_LWLO];
                regs_q <= wd_q[`NVC_BIT_REGS];
                ie_q <= wd_q[`NVC_BIT_IE];
            end
            // Key sequence; any other bus write breaks it
            if (wr_key) begin
                key_q <= wd_q[7:0] == `NVC_KEY1 ? 2'd1 :
                    (wd_q[7:0] == `NVC_KEY2 && key_q == 2'd1) ? 2'd2 : 2'd0;
            end else if (wr_go) begin
                key_q <= 2'd0;
            end
            case (state_q)
                nvc_pkg::NVC_IDLE: begin
                    if (start_wr && target_ok) begin
                        wr_q <= 1'b1;
                        op_q <= op_w;
                        tmr_q <= latch_only ? 16'd1 : 16'(WRITE_CYC);
                        state_q <= nvc_pkg::NVC_BUSY;
                    end
                end
                nvc_pkg::NVC_BUSY: begin
                    // Clearing WR by software has no effect here
                    if (tmr_q == 16'd1) begin
                        wr_q <= 1'b0;
                        state_q <= nvc_pkg::NVC_IDLE;
                    end
                    tmr_q <= tmr_q - 16'd1;
                end
                default: state_q <= nvc_pkg::NVC_IDLE;
            endcase
            // Done flag: set wins over software clear
            if (state_q == nvc_pkg::NVC_BUSY && tmr_q == 16'd1 && op_q != nvc_pkg::NVC_OP_LATCH)
                done_q <= 1'b1;
            else if (wr_stat && ws_q[0] && wd_q[0])
                done_q <= 1'b0;
            done_irq_q <= done_q && ie_q;
        end
    end

    // Memory updates: latch load at launch, all others at end of timed operation
    wire logic finish = state_q == nvc_pkg::NVC_BUSY && tmr_q == 16'd1;
    wire logic [12:0] row_base = {fa_w[12:5], 5'h00};
    always @(posedge aclk) begin
        if (start_wr && target_ok && latch_only)
            latch_mem[addr_q[4:0]] <= data_q;
        if (finish && op_q == nvc_pkg::NVC_OP_EE)
            ee_mem[addr_q[7:0]] <= data_q[7:0];
        if (finish && op_q == nvc_pkg::NVC_OP_ERASE && !uid_sel_w) begin
            for (int i = 0; i < `NVC_ROW_WORDS; i++)
                flash_mem[row_base + 13'(i)] <= 14'h3fff;
        end
        if (finish && op_q == nvc_pkg::NVC_OP_ROW && !uid_sel_w) begin
            for (int i = 0; i < `NVC_ROW_WORDS; i++)
                flash_mem[row_base + 13'(i)] <= flash_mem[row_base + 13'(i)] & latch_mem[i];
        end
        if (finish && uid_sel_w && op_q == nvc_pkg::NVC_OP_ROW)
            uid_mem[addr_q[1:0]] <= latch_mem[addr_q[4:0]];
        if (finish && uid_sel_w && op_q == nvc_pkg::NVC_OP_ERASE)
            uid_mem[addr_q[1:0]] <= 14'h3fff;
    end

    // Address, data pair and pointer data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr_q <= 16'h0000;
            data_q <= 14'h0000;
            ptr_data_q <= 14'h0000;
            cpu_stall_q <= 1'b0;
        end else begin
            if (wr_addr)
                addr_q <= wd_q[15:0];
            if (do_rd)
                data_q <= rd_word;
            else if (wr_data)
                data_q <= wd_q[13:0];
            if (ptr_rd)
                ptr_data_q <= ptr_word;
            cpu_stall_q <= do_rd || ptr_rd || (start_wr && target_ok && !ee_sel_w);
        end
    end

    // Read trigger self-clears one cycle after it is set
    property p_rd_clear;
        @(posedge aclk) disable iff (!aresetn) rd_q |=> !rd_q;
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("read trigger stuck");

    // Read loads data pair with the selected word next cycle
    property p_rd_data;
        @(posedge aclk) disable iff (!aresetn) do_rd |=> data_q == $past(rd_word);
    endproperty
    a_rd_data: assert property (p_rd_data) else $error("read data wrong");

    // Data pair holds when neither read nor write
    property p_hold;
        @(posedge aclk) disable iff (!aresetn) !do_rd && !wr_data |=> $stable(data_q);
    endproperty
    a_hold: assert property (p_hold) else $error("data pair changed");

    // Protected device never starts an operation
    property p_cp;
        @(posedge aclk) disable iff (!aresetn) protected_w |-> !start_wr && !do_rd;
    endproperty
    a_cp: assert property (p_cp) else $error("protected access allowed");

    // Write starts only straight after the two keys
    property p_unlock;
        @(posedge aclk) disable iff (!aresetn)
            $rose(wr_q) |-> $past(key_q) == 2'd2;
    endproperty
    a_unlock: assert property (p_unlock) else $error("write without unlock");

    // Busy read requests do not run
    property p_busy_rd;
        @(posedge aclk) disable iff (!aresetn) set_rd && !idle_w |=> !rd_q;
    endproperty
    a_busy_rd: assert property (p_busy_rd) else $error("read during write");

    // End of EEPROM write clears WR and raises done
    property p_done;
        @(posedge aclk) disable iff (!aresetn)
            finish && op_q == nvc_pkg::NVC_OP_EE |=> !wr_q && done_q;
    endproperty
    a_done: assert property (p_done) else $error("done not flagged");

    // Protected row erase never starts
    property p_wp;
        @(posedge aclk) disable iff (!aresetn)
            start_wr && fl_sel_w && wp_hit(cfg_q.wrt_field, fa_w) |=> !wr_q;
    endproperty
    a_wp: assert property (p_wp) else $error("protected erase ran");

    // Pointer read raises the core stall on the next cycle
    property p_ptr;
        @(posedge aclk) disable iff (!aresetn) ptr_rd |=> cpu_stall_q;
    endproperty
    a_ptr: assert property (p_ptr) else $error("pointer read no stall");
endmodule // nvc_ctrl

// [pkg/nvc_params.svh]
// Constants for the nonvolatile memory controller: offsets, fields, keys, windows, timing.
// Assumes inclusion by the controller module and the test bench only.
// Functional notes
// - Internal timer times every program and erase
// - Code protect blocks external programmer access
// - Only external bulk erase clears protection
// - Write-protect region refuses self-write and erase
// - Erased bits read one, programming clears
// - Flash rows of 32 fourteen-bit words
// - Row data passes through write latches
// - Unprogrammed words writable without row erase
// - No bulk erase during self-programming
// - EEPROM holds 256 eight-bit locations
// - EEPROM written one location at a time
// - Flash read-only for fetch and pointer
// - Pointer read stalls one cycle, one word
// - Pointer store never writes or erases
// - Register access covers IDs; config read-only
// - Code-protected device blocks register access
// - Space-select bit routes flash or config/EEPROM
// - Read stalls core, data next cycle
// - Data pair holds until read or write
// - Hardware clears read trigger after read
// - Unlock 55h then AAh then write trigger
// - EEPROM done clears trigger, sets flag
// - Protected row erase clears trigger, skipped
`ifndef NVC_PARAMS_SVH
`define NVC_PARAMS_SVH

// Register byte offsets on the bus
`define NVC_OFF_CTRL 8'h00
`define NVC_OFF_KEY 8'h04
`define NVC_OFF_ADDR 8'h08
`define NVC_OFF_DATA 8'h0c
`define NVC_OFF_PTR 8'h10
`define NVC_OFF_STAT 8'h14

// Control register fields
`define NVC_BIT_RD 0
`define NVC_BIT_WR 1
`define NVC_BIT_WRITE_ENABLE_GATE 2
`define NVC_BIT_FREE 3
`define NVC_BIT_LWLO 5
`define NVC_BIT_REGS 6
`define NVC_BIT_IE 7
`define NVC_BIT_DONE 8

// Unlock keys and address windows
`define NVC_KEY1 8'h55
`define NVC_KEY2 8'haa
`define NVC_EE_BASE 16'hf000
`define NVC_FLASH_BASE 16'h8000
`define NVC_UID_TOP 16'h0003
`define NVC_ROW_WORDS 32
`define NVC_FLASH_WORDS 8192

// Write timing: nanoseconds and derived 10 ns cycles
`define NVC_CLK_NS 10
`define NVC_WRITE_NS 20000
`define NVC_WRITE_CYC ((`NVC_WRITE_NS + `NVC_CLK_NS - 1) / `NVC_CLK_NS)

`endif

// [pkg/nvc_pkg.sv]
// Types for the nonvolatile memory controller.
// Assumes nvc_params.svh is included by its users.
package nvc_pkg;
    typedef enum logic [1:0] {
        NVC_IDLE,
        NVC_BUSY
    } nvc_state_e;

    typedef enum logic [1:0] {
        NVC_OP_ERASE,
        NVC_OP_LATCH,
        NVC_OP_ROW,
        NVC_OP_EE
    } nvc_op_e;

    // Configuration straps the device reads one edge after each reset release
    typedef struct packed {
        logic cp_flash_n;
        logic cp_ee_n;
        logic [1:0] wrt_field;
    } nvc_cfg_s;
endpackage

// [testbench/nvc_core_model.sv]
// Processor core model: issues indirect pointer reads and watches the stall pulse.
// Assumes the controller registers pointer data one cycle after the request edge.
`timescale 1ns/1ps

module nvc_core_model (
    input wire logic aclk,
    output logic ptr_rd,
    output logic [15:0] ptr_addr,
    input wire logic [13:0] ptr_data_q,
    input wire logic cpu_stall_q
);
    // Idle request lines at time zero
    initial begin
        ptr_rd = 1'b0;
        ptr_addr = 16'h0000;
    end

    // One-word pointer load, core stalled for one cycle
    task automatic fetch(input logic [15:0] a, output logic [13:0] d, output logic stall);
        @(posedge aclk);
        ptr_rd <= 1'b1;
        ptr_addr <= a;
        @(posedge aclk);
        ptr_rd <= 1'b0;
        ptr_addr <= ~a; // Released address shows junk
        #1;
        d = ptr_data_q;
        stall = cpu_stall_q;
    endtask

    // No pointer store path is ever driven
endmodule // nvc_core_model

// [testbench/nvm_control_read_path_test.sv]
// Self-checking bench for the memory controller over its AXI4-Lite registers.
// Assumes the controller package, its constants header and the core model.
`timescale 1ns/1ps
`include "nvc_params.svh"

module nvm_control_read_path_test;
    localparam logic [31:0] RD = 32'h1 << `NVC_BIT_RD;
    localparam logic [31:0] WR = 32'h1 << `NVC_BIT_WR;
    localparam logic [31:0] WRITE_ENABLE_GATE = 32'h1 << `NVC_BIT_WRITE_ENABLE_GATE;
    localparam logic [31:0] FREE = 32'h1 << `NVC_BIT_FREE;
    localparam logic [31:0] LWLO = 32'h1 << `NVC_BIT_LWLO;
    localparam logic [31:0] REGS = 32'h1 << `NVC_BIT_REGS;
    localparam logic [31:0] IE = 32'h1 << `NVC_BIT_IE;
    localparam logic [31:0] DONE = 32'h1 << `NVC_BIT_DONE;
    logic aclk = 1'b0;
    logic aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [7:0] s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata, d;
    logic [3:0] s_wstrb;
    logic [1:0] s_bresp, s_rresp, r, b;
    nvc_pkg::nvc_cfg_s cfg;
    logic ptr_rd, cpu_stall_q, done_irq_q, ps;
    logic [15:0] ptr_addr;
    logic [13:0] ptr_data_q, pd;
    int n_mismatch = 0;
    int n_checks = 0;

    // 100 MHz clock
    always #5 aclk = ~aclk;

    nvc_ctrl #(.WRITE_CYC(20)) dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
        .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
        .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
        .s_rready(s_rready), .cfg(cfg), .ptr_rd(ptr_rd), .ptr_addr(ptr_addr),
        .ptr_data_q(ptr_data_q), .cpu_stall_q(cpu_stall_q), .done_irq_q(done_irq_q));

    nvc_core_model core (.aclk(aclk), .ptr_rd(ptr_rd), .ptr_addr(ptr_addr),
        .ptr_data_q(ptr_data_q), .cpu_stall_q(cpu_stall_q));

    // Verdict and end of run
    task automatic results();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Compare and report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Expired wait ends the run
    task automatic tmo();
        n_mismatch++;
        $display("ERROR at %0t: wait expired got %h expected %h", $time, 32'h0, 32'h1);
        results();
    endtask

    // AXI4-Lite write: address and data offered together, held until taken
    task automatic axw(input logic [7:0] a, input logic [31:0] v);
        int i;
        @(posedge aclk);
        s_awaddr <= a;
        s_awvalid <= 1'b1;
        s_wdata <= v;
        s_wstrb <= 4'hf;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        for (i = 0; i < 200; i++) begin
            @(posedge aclk);
            if (s_awvalid && s_awready) s_awvalid <= 1'b0;
            if (s_wvalid && s_wready) s_wvalid <= 1'b0;
            if (s_bvalid) begin
                b = s_bresp;
                break;
            end
        end
        s_bready <= 1'b0;
        if (i == 200) tmo();
    endtask

    // AXI4-Lite read: data and response taken at the rvalid edge
    task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
        int i;
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        for (i = 0; i < 200; i++) begin
            @(posedge aclk);
            if (s_rvalid) break;
            if (s_arvalid && s_arready) s_arvalid <= 1'b0;
        end
        v = s_rdata;
        rr = s_rresp;
        s_rready <= 1'b0;
        if (i == 200) tmo();
    endtask

    // Space select, address, then read trigger
    task automatic rd_word(input logic [15:0] a, input logic [31:0] sel, output logic [31:0] v);
        logic [1:0] rr;
        axw(`NVC_OFF_CTRL, sel);
        axw(`NVC_OFF_ADDR, {16'h0000, a});
        axw(`NVC_OFF_CTRL, sel | RD);
        axr(`NVC_OFF_DATA, v, rr);
    endtask

    // Key pair followed by the control write
    task automatic unl(input logic [31:0] c);
        axw(`NVC_OFF_KEY, {24'h0, `NVC_KEY1});
        axw(`NVC_OFF_KEY, {24'h0, `NVC_KEY2});
        axw(`NVC_OFF_CTRL, c);
    endtask

    // Poll the write trigger until hardware drops it
    task automatic wait_wr();
        int j;
        logic [31:0] v;
        logic [1:0] rr;
        for (j = 0; j < 50; j++) begin
            axr(`NVC_OFF_CTRL, v, rr);
            if (v[`NVC_BIT_WR] === 1'b0) break;
        end
        if (j == 50) tmo();
    endtask

    // Reset held 20 cycles with new straps
    task automatic do_reset(input logic [3:0] c);
        @(posedge aclk);
        aresetn <= 1'b0;
        cfg <= nvc_pkg::nvc_cfg_s'(c);
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
    endtask

    // Main sequence
    initial begin
        {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 6'h00;
        {s_awaddr, s_araddr, s_wdata, s_wstrb} = 52'h0;
        cfg = nvc_pkg::nvc_cfg_s'(4'hf);
        do_reset(4'hf);
        axr(`NVC_OFF_CTRL, d, r); chk(d & (RD | WR), 32'h0);
        axr(`NVC_OFF_STAT, d, r); chk(d & 32'h1f, 32'h0c);
        axr(8'h18, d, r); chk({30'h0, r}, 32'h2);
        axw(8'h18, 32'h0); chk({30'h0, b}, 32'h2);
        axw(`NVC_OFF_ADDR, 32'h0); chk({30'h0, b}, 32'h0);
        axw(`NVC_OFF_PTR, 32'h3fff); axr(`NVC_OFF_PTR, d, r); chk(d, 32'h0);
        rd_word(16'h8000, 32'h0, d); chk(d, 32'h3fff);
        axr(`NVC_OFF_CTRL, d, r); chk(d & RD, 32'h0);
        // Single EEPROM location write with completion flag
        axw(`NVC_OFF_CTRL, REGS | WRITE_ENABLE_GATE | IE);
        axw(`NVC_OFF_ADDR, 32'hf005);
        axw(`NVC_OFF_DATA, 32'h5a);
        unl(REGS | WRITE_ENABLE_GATE | IE | WR); wait_wr();
        axr(`NVC_OFF_CTRL, d, r); chk(d & (WR | WRITE_ENABLE_GATE | DONE), WRITE_ENABLE_GATE | DONE);
        chk({31'h0, done_irq_q}, 32'h1);
        axw(`NVC_OFF_STAT, 32'h1); repeat (2) @(posedge aclk);
        chk({31'h0, done_irq_q}, 32'h0);
        rd_word(16'hf005, REGS, d); chk(d & 32'hff, 32'h5a);
        axw(`NVC_OFF_DATA, 32'h2a55); axr(`NVC_OFF_CTRL, d, r);
        axr(`NVC_OFF_DATA, d, r); chk(d, 32'h2a55);
        // Read trigger while an EEPROM write runs
        axw(`NVC_OFF_ADDR, 32'hf006); axw(`NVC_OFF_DATA, 32'h33);
        unl(REGS | WRITE_ENABLE_GATE | WR); axw(`NVC_OFF_CTRL, REGS | WRITE_ENABLE_GATE | RD);
        axr(`NVC_OFF_DATA, d, r); chk(d, 32'h33);
        wait_wr();
        core.fetch(16'hf005, pd, ps); chk({18'h0, pd} & 32'hff, 32'h5a);
        chk({31'h0, ps}, 32'h1);
        // Latch load, row write to an unprogrammed word, then row erase
        axw(`NVC_OFF_CTRL, WRITE_ENABLE_GATE); axw(`NVC_OFF_ADDR, 32'h8001); axw(`NVC_OFF_DATA, 32'h1555);
        unl(WRITE_ENABLE_GATE | LWLO | WR); wait_wr(); unl(WRITE_ENABLE_GATE | WR); wait_wr();
        rd_word(16'h8001, 32'h0, d); chk(d, 32'h1555);
        core.fetch(16'h8001, pd, ps); chk({18'h0, pd}, 32'h1555);
        axw(`NVC_OFF_ADDR, 32'h801f); unl(WRITE_ENABLE_GATE | FREE | WR); wait_wr();
        rd_word(16'h8001, 32'h0, d); chk(d, 32'h3fff);
        // Broken unlock sequences
        axw(`NVC_OFF_KEY, 32'haa); axw(`NVC_OFF_KEY, 32'h55); axw(`NVC_OFF_CTRL, WRITE_ENABLE_GATE | WR);
        axr(`NVC_OFF_CTRL, d, r); chk(d & WR, 32'h0);
        axw(`NVC_OFF_KEY, 32'h55); axw(`NVC_OFF_ADDR, 32'h8002);
        axw(`NVC_OFF_KEY, 32'haa); axw(`NVC_OFF_CTRL, WRITE_ENABLE_GATE | WR);
        axr(`NVC_OFF_CTRL, d, r); chk(d & WR, 32'h0);
        unl(WR); axr(`NVC_OFF_CTRL, d, r); chk(d & WR, 32'h0);
        // Whole flash write-protected
        do_reset(4'hc);
        axw(`NVC_OFF_CTRL, WRITE_ENABLE_GATE); axw(`NVC_OFF_ADDR, 32'h8003); unl(WRITE_ENABLE_GATE | FREE | WR);
        axr(`NVC_OFF_CTRL, d, r); chk(d & WR, 32'h0);
        axw(`NVC_OFF_DATA, 32'h0); unl(WRITE_ENABLE_GATE | LWLO | WR); wait_wr(); unl(WRITE_ENABLE_GATE | WR); wait_wr();
        rd_word(16'h8003, 32'h0, d); chk(d, 32'h3fff);
        // Code-protected device
        do_reset(4'h7);
        axr(`NVC_OFF_STAT, d, r); chk(d & 32'h10, 32'h10);
        axw(`NVC_OFF_DATA, 32'h0abc); rd_word(16'h8000, 32'h0, d); chk(d, 32'h0abc);
        axw(`NVC_OFF_ADDR, 32'hf005); unl(REGS | WRITE_ENABLE_GATE | WR);
        axr(`NVC_OFF_CTRL, d, r); chk(d & WR, 32'h0);
        results();
    end
endmodule // nvm_control_read_path_test
